// [core/scp_switch_ctrl.sv]
// Control and protection latch logic for a four channel high-side switch
//
// Behaviour
// - channel_on_bit 1 switches channel on, readable
// - LED mode bits exist for channels 3, 2
// - Input config bit 2 selects direct or assigned drive
// - Input config bit 3 picks OR or AND
// - Over-current trips off, limited restarts, then latch
// - Error flag set in shutdown; read clears, resets
// - During restart flag stays set; read clears once back on
// - Writing clear_latch_bit 1 releases the latches
// - After clear, channel on again if demanded
// - High Vds plus low trip at turn-on latches
// - After trip delay, use reduced trip threshold
// - Trip delay restarts on shutdown or command change
// - Reduced-level short in on state latches immediately
// - Over-temperature switches channel off and latches
// - Over-temperature latch needs cool-down and clear
// - Trip activation delay lasts 7 ms (TRIP_DELAY_CYC cycles)
`timescale 1ns/1ps
`default_nettype none

module scp_switch_ctrl #(
  parameter int TRIP_DELAY_CYC = scp_pkg::TRIP_DELAY_CYC
) (
  input  wire logic        sys_clk_i,         // 40 MHz clock
  input  wire logic        rst_n_i,           // Async reset, active low
  input  wire logic [3:0]  in_pin_i,          // Input pins, asynchronous
  input  wire logic [3:0]  oc_trip_i,         // Over-current comparators
  input  wire logic [3:0]  reduced_trip_i,    // Reduced level comparators
  input  wire logic [3:0]  low_trip_i,        // High-Vds low level trip
  input  wire logic [3:0]  high_vds_i,        // Vds above high threshold
  input  wire logic [3:0]  over_temp_i,       // Over-temp, with hysteresis
  input  wire logic [15:0] retry_limit_i,     // Retry limit, 4 bits per ch
  input  wire logic        reg_wr_i,          // Register write strobe
  input  wire logic        reg_rd_i,          // Register read strobe
  input  wire logic [1:0]  reg_sel_i,         // Register select
  input  wire logic [3:0]  reg_wdata_i,       // Register write data
  output logic      [3:0]  reg_rdata_o,       // Register read data
  output logic      [3:0]  ch_on_o,           // Channel gate enables
  output logic      [3:0]  reduced_sel_o,     // Reduced threshold in use
  output logic      [3:0]  latched_o,         // Channel latched off
  output logic      [1:0]  led_mode_o,        // LED mode, ch3 and ch2
  output logic             current_sense_o    // Current source select
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;                         // First reset stage
  logic rst_n_sync;                           // Released reset copy

  // Releases the asynchronous reset through two flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'h0;
      rst_n_sync   <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 40;                 // All asynchronous inputs
  logic [SYNC_W-1:0] sync_meta_reg;           // First stage, read once
  logic [SYNC_W-1:0] sync_reg;                // Usable copy
  logic [3:0]        pin_s;                   // Synced pins
  logic [3:0]        oc_s;                    // Synced over-current
  logic [3:0]        red_s;                   // Synced reduced trip
  logic [3:0]        low_s;                   // Synced low trip
  logic [3:0]        hv_s;                    // Synced high Vds
  logic [3:0]        ot_s;                    // Synced over-temperature
  logic [15:0]       lim_s;                   // Synced retry limits

  // Two flop synchroniser for pins and comparator results
  always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      sync_meta_reg <= '0;
      sync_reg      <= '0;
    end else begin
      sync_meta_reg <= {retry_limit_i, over_temp_i, high_vds_i,
                        low_trip_i, reduced_trip_i, oc_trip_i, in_pin_i};
      sync_reg      <= sync_meta_reg;
    end
  end

  assign {lim_s, ot_s, hv_s, low_s, red_s, oc_s, pin_s} = sync_reg;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [3:0] out_cmd_reg;                    // output_command
  logic [1:0] led_reg;                        // LED mode bits
  logic       sense_reg;                      // current_sense_select
  logic       assign_reg;                     // drive_assignment_select
  logic       and_mode_reg;                   // Combine mode
  logic       clear_pulse;                    // Latch clear command
  logic [3:0] err_reg;                        // Error flags
  logic       wr_out;                         // Write to output_command
  logic       wr_hw;                          // Write to hw config
  logic       wr_ic;                          // Write to input config

  assign wr_out = reg_wr_i && (reg_sel_i == scp_pkg::SEL_OUTPUT_CMD);
  assign wr_hw  = reg_wr_i && (reg_sel_i == scp_pkg::SEL_HW_CFG);
  assign wr_ic  = reg_wr_i && (reg_sel_i == scp_pkg::SEL_INPUT_CFG);
  // Clear command is a write, the bit itself is not stored
  assign clear_pulse = wr_hw &&
                       reg_wdata_i[scp_pkg::HW_CLEAR_LATCH_POS];

  // Channel on command bits
  always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      out_cmd_reg <= scp_pkg::OUTPUT_CMD_RST;
    end else if (wr_out) begin
      out_cmd_reg <= reg_wdata_i;
    end
  end

  // Hardware configuration: LED modes for channels 3 and 2
  always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      led_reg <= scp_pkg::LED_MODE_RST;
    end else if (wr_hw) begin
      led_reg <= {reg_wdata_i[scp_pkg::HW_LED3_POS],
                  reg_wdata_i[scp_pkg::HW_LED2_POS]};
    end
  end

  // Input and current source configuration
  always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      sense_reg    <= scp_pkg::SENSE_RST;
      assign_reg   <= scp_pkg::ASSIGN_RST;
      and_mode_reg <= scp_pkg::AND_MODE_RST;
    end else if (wr_ic) begin
      sense_reg    <= reg_wdata_i[scp_pkg::IC_SENSE_POS];
      assign_reg   <= reg_wdata_i[scp_pkg::IC_ASSIGN_POS];
      and_mode_reg <= reg_wdata_i[scp_pkg::IC_AND_POS];
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic       err_rd;                         // Error flags read now
  logic [3:0] rdata_next;                     // Selected read data

  assign err_rd = reg_rd_i && (reg_sel_i == scp_pkg::SEL_ERROR);

  // Read data mux; clear bit and reserved bits read zero
  always_comb begin
    rdata_next = reg_rdata_o;
    if (reg_rd_i) begin
      case (reg_sel_i)
        scp_pkg::SEL_OUTPUT_CMD: rdata_next = out_cmd_reg;
        scp_pkg::SEL_HW_CFG:     rdata_next = {led_reg, 2'h0};
        scp_pkg::SEL_INPUT_CFG:
          rdata_next = {and_mode_reg, assign_reg, sense_reg, 1'h0};
        default:                 rdata_next = err_reg;
      endcase
    end
  end

  // Read data holds until the next read
  always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      reg_rdata_o <= 4'h0;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Drive demand per channel
  // ---------------------------------------------------------------
  logic [3:0] pin_route;                      // Pin seen by each channel
  logic [3:0] demand;                         // Combined on request
  logic [3:0] demand_d_reg;                   // Demand one cycle ago

  // Assigned mode: pin 0 drives ch 0 and 2, pin 1 drives ch 1 and 3
  assign pin_route = assign_reg ? {pin_s[1], pin_s[0], pin_s[1], pin_s[0]}
                                : pin_s;
  assign demand = and_mode_reg ? (pin_route & out_cmd_reg)
                               : (pin_route | out_cmd_reg);

  // Remembers demand to spot changes and rising edges
  always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      demand_d_reg <= 4'h0;
    end else begin
      demand_d_reg <= demand;
    end
  end

  // ---------------------------------------------------------------
  // Channel protection state machines
  // ---------------------------------------------------------------
  logic [3:0] err_set;                        // Error set requests
  logic [3:0] on_next;                        // Gate enables, next
  logic [3:0] red_next;                       // Reduced threshold, next
  logic [3:0] lat_next;                       // Latched state, next

  genvar ch;
  generate
    for (ch = 0; ch < scp_pkg::NUM_CH; ch++) begin : g_ch
      scp_pkg::scp_ch_state_type       st_reg;     // Channel state
      logic [scp_pkg::RETRY_W-1:0]     retry_reg;  // Restarts so far
      logic [scp_pkg::DELAY_W-1:0]     dly_reg;    // Trip delay counter
      logic [scp_pkg::SHORT_W-1:0]     tmr_reg;    // Turn-on / restart
      logic                            reduced;    // Delay elapsed
      logic                            turning_on; // In turn-on window
      logic                            wait_done;  // Restart time over
      logic                            changed;    // Demand changed
      logic                            rise;       // Demand went high
      logic                            oc_hit;     // Normal trip, on
      logic                            hard_hit;   // Trip with no retry
      logic                            at_limit;   // Retries used up
      logic                            release_ok; // Clear may release

      assign reduced    = (dly_reg ==
                           scp_pkg::DELAY_W'(TRIP_DELAY_CYC));
      assign turning_on = (tmr_reg < scp_pkg::SHORT_W'(scp_pkg::TURN_ON_CYC));
      assign wait_done  = (tmr_reg >= scp_pkg::SHORT_W'(scp_pkg::RESTART_CYC));
      assign changed    = demand[ch] ^ demand_d_reg[ch];
      assign rise       = demand[ch] & ~demand_d_reg[ch];
      assign oc_hit     = (st_reg == scp_pkg::CH_ON) && oc_s[ch];
      // High Vds at turn-on, or short above the reduced level
      assign hard_hit   = (st_reg == scp_pkg::CH_ON) &&
                          ((hv_s[ch] && low_s[ch] && turning_on) ||
                           (reduced && red_s[ch]));
      assign at_limit   = (retry_reg >= lim_s[ch*4 +: 4]);
      // A hot channel stays latched until cooled by the hysteresis
      assign release_ok = clear_pulse && !ot_s[ch];

      // Channel state sequence
      always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          st_reg     <= scp_pkg::CH_OFF;
        end else begin
          case (st_reg)
            scp_pkg::CH_OFF: begin
              if (ot_s[ch]) begin
                st_reg <= scp_pkg::CH_LATCHED;
              end else if (demand[ch]) begin
                st_reg <= scp_pkg::CH_ON;
              end
            end
            scp_pkg::CH_ON: begin
              if (ot_s[ch]) begin
                st_reg <= scp_pkg::CH_LATCHED;
              end else if (hard_hit) begin
                st_reg <= scp_pkg::CH_LATCHED;
              end else if (oc_hit) begin
                st_reg <= at_limit ? scp_pkg::CH_LATCHED
                                   : scp_pkg::CH_RESTART;
              end else if (!demand[ch]) begin
                st_reg <= scp_pkg::CH_OFF;
              end
            end
            scp_pkg::CH_RESTART: begin
              if (ot_s[ch]) begin
                st_reg <= scp_pkg::CH_LATCHED;
              end else if (wait_done) begin
                st_reg <= demand[ch] ? scp_pkg::CH_ON
                                     : scp_pkg::CH_OFF;
              end
            end
            scp_pkg::CH_LATCHED: begin
              if (release_ok) begin
                st_reg <= demand[ch] ? scp_pkg::CH_ON
                                     : scp_pkg::CH_OFF;
              end
            end
            default: begin
              st_reg <= scp_pkg::CH_OFF;
            end
          endcase
        end
      end

      // Restart counter, cleared by a new turn-on request below the limit or a clear
      always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          retry_reg <= '0;
        end else if (st_reg == scp_pkg::CH_LATCHED) begin
          if (release_ok) begin
            retry_reg <= '0;
          end
        end else if (oc_hit && !hard_hit && !ot_s[ch]) begin
          retry_reg <= retry_reg + 1'b1;
        end else if (rise && !at_limit) begin
          retry_reg <= '0;
        end
      end

      // Trip activation delay, counted only while on
      always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          dly_reg <= '0;
        end else if (st_reg != scp_pkg::CH_ON || changed ||
                     oc_hit || ot_s[ch]) begin
          dly_reg <= '0;
        end else if (!reduced) begin
          dly_reg <= dly_reg + 1'b1;
        end
      end

      // Turn-on window and restart wait share one timer
      always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          tmr_reg <= '0;
        end else if (st_reg == scp_pkg::CH_OFF ||
                     st_reg == scp_pkg::CH_LATCHED ||
                     (st_reg == scp_pkg::CH_ON && oc_hit) ||
                     (st_reg == scp_pkg::CH_RESTART && wait_done)) begin
          tmr_reg <= '0;
        end else if (tmr_reg != '1) begin
          tmr_reg <= tmr_reg + 1'b1;
        end
      end

      // Error raised while shut down or latched
      assign err_set[ch]  = (st_reg == scp_pkg::CH_RESTART) ||
                            (st_reg == scp_pkg::CH_LATCHED) ||
                            oc_hit;
      assign on_next[ch]  = (st_reg == scp_pkg::CH_ON) && !oc_hit &&
                            !hard_hit && !ot_s[ch] && demand[ch];
      assign red_next[ch] = reduced;
      assign lat_next[ch] = (st_reg == scp_pkg::CH_LATCHED);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Error flags and outputs
  // ---------------------------------------------------------------
  // Read clears a flag; a standing fault sets it again, set wins
  always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      err_reg <= 4'h0;
    end else begin
      err_reg <= err_set | (err_reg & {4{~err_rd}});
    end
  end

  // Registered outputs toward the power stages
  always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ch_on_o         <= 4'h0;
      reduced_sel_o   <= 4'h0;
      latched_o       <= 4'h0;
      led_mode_o      <= scp_pkg::LED_MODE_RST;
      current_sense_o <= scp_pkg::SENSE_RST;
    end else begin
      ch_on_o         <= on_next;
      reduced_sel_o   <= red_next;
      latched_o       <= lat_next;
      led_mode_o      <= led_reg;
      current_sense_o <= sense_reg;
    end
  end

endmodule // scp_switch_ctrl

`default_nettype wire

// [pkg/scp_pkg.sv]
// Shared constants and types for the switch channel control block
package scp_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CH    = 4;   // Power channels
  localparam int unsigned REG_W     = 4;   // Register data width
  localparam int unsigned RETRY_W   = 4;   // Retry limit / count width
  localparam int unsigned DELAY_W   = 20;  // Trip delay counter width
  localparam int unsigned SHORT_W   = 13;  // Short timer width

  // ---------------------------------------------------------------
  // Register selects on the register port
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_OUTPUT_CMD = 2'h0; // output_command
  localparam logic [1:0] SEL_HW_CFG     = 2'h1; // hardware_configuration
  localparam logic [1:0] SEL_INPUT_CFG  = 2'h2; // input_source_configuration
  localparam logic [1:0] SEL_ERROR      = 2'h3; // Error flags, clear on read

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned HW_CLEAR_LATCH_POS = 0; // clear_latch_bit
  localparam int unsigned HW_LED2_POS        = 2; // led_load_mode_bit ch2
  localparam int unsigned HW_LED3_POS        = 3; // led_load_mode_bit ch3
  localparam int unsigned IC_SENSE_POS       = 1; // current_sense_select
  localparam int unsigned IC_ASSIGN_POS      = 2; // drive_assignment_select
  localparam int unsigned IC_AND_POS         = 3; // Combine mode, 1 = AND

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] OUTPUT_CMD_RST = 4'h0;
  localparam logic [1:0]       LED_MODE_RST   = 2'h0;
  localparam logic             SENSE_RST      = 1'h0;
  localparam logic             ASSIGN_RST     = 1'h0;
  localparam logic             AND_MODE_RST   = 1'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ          = 40_000_000;
  localparam longint TRIP_DELAY_MS   = 7;    // Least trip activation delay
  localparam longint TURN_ON_US      = 100;  // Turn-on window for high Vds
  localparam longint RESTART_US      = 100;  // Off time before a restart
  localparam int TRIP_DELAY_CYC =
    int'((TRIP_DELAY_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam int TURN_ON_CYC =
    int'((TURN_ON_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
  localparam int RESTART_CYC =
    int'((RESTART_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);

  // ---------------------------------------------------------------
  // Channel states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CH_OFF,
    CH_ON,
    CH_RESTART,
    CH_LATCHED
  } scp_ch_state_type;

endpackage

// [verification/scp_host_model.sv]
// Host register master model driving the register port
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
  input  wire logic       sys_clk_i,   // Register port clock
  output var  logic       reg_wr_o,    // Write strobe
  output var  logic       reg_rd_o,    // Read strobe
  output var  logic [1:0] reg_sel_o,   // Register select
  output var  logic [3:0] reg_wdata_o  // Write data
);
  initial {reg_wr_o, reg_rd_o, reg_sel_o, reg_wdata_o} = 8'h00;
  // One write over one edge, then an idle cycle
  task automatic wr(input logic [1:0] sel, input logic [3:0] d);
    reg_sel_o = sel;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge sys_clk_i);
    #1 reg_wr_o = 1'b0;
    reg_wdata_o = ~d;  // Released data shows no stale value
    @(posedge sys_clk_i);
    #1;
  endtask
  // One read over one edge, then an idle cycle
  task automatic rd(input logic [1:0] sel);
    reg_sel_o = sel;
    reg_rd_o = 1'b1;
    @(posedge sys_clk_i);
    #1 reg_rd_o = 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask
  // Latch release command
  task automatic clear();
    wr(2'h1, 4'h1);
  endtask
endmodule // scp_host_model
`default_nettype wire

// [verification/scp_switch_ctrl_monitor.sv]
// Assertion checker for the switch channel control block
`timescale 1ns/1ps
`default_nettype none
module scp_switch_ctrl_monitor #(
  parameter int TRIP_DELAY_CYC = scp_pkg::TRIP_DELAY_CYC  // Trip delay, cycles
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic [3:0] over_temp_i,
  input wire logic [3:0] reduced_trip_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [3:0] reg_wdata_i,
  input wire logic [3:0] reg_rdata_o,
  input wire logic [3:0] ch_on_o,
  input wire logic [3:0] reduced_sel_o,
  input wire logic [3:0] latched_o,
  input wire logic [1:0] led_mode_o
);
  // ----------------------------------------------------------
  // Helper logic and properties
  // ----------------------------------------------------------
  logic [19:0] on_cnt;  // Cycles channel 0 has been on
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Saturating on-time counter of channel 0
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) on_cnt <= 20'h0;
    else if (!ch_on_o[0]) on_cnt <= 20'h0;
    else if (on_cnt != 20'hFFFFF) on_cnt <= on_cnt + 20'h1;
  end
  sequence s_clr;
    latched_o[0] && reg_wr_i && reg_sel_i == 2'h1 && reg_wdata_i[0];
  endsequence
  sequence s_hot; over_temp_i[0] [*4]; endsequence
  sequence s_cool; !over_temp_i[0] [*4]; endsequence
  property p_led; reg_wr_i && reg_sel_i == 2'h1
    |=> ##1 led_mode_o == $past(reg_wdata_i[3:2], 2); endproperty
  property p_rd_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  property p_latch_off;
    (latched_o & ch_on_o & $past(latched_o)) == 4'h0; endproperty
  property p_ot; over_temp_i[0] [*5] |-> !ch_on_o[0]; endproperty
  property p_clear_hot; s_hot ##0 s_clr |=> latched_o[0]; endproperty
  property p_clear_on; s_cool ##0 s_clr |-> ##[1:3] !latched_o[0];
  endproperty
  property p_red_lat; reduced_sel_o[0] ##0 reduced_trip_i[0] [*5]
    |-> ##[0:2] latched_o[0]; endproperty
  property p_red_delay;
    $rose(reduced_sel_o[0]) |-> on_cnt >= TRIP_DELAY_CYC - 3; endproperty
  a_led: assert property (p_led)
    else $error("led mode does not follow write");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  a_latch_off: assert property (p_latch_off)
    else $error("latched channel is on");
  a_ot: assert property (p_ot)
    else $error("hot channel still on");
  a_clear_hot: assert property (p_clear_hot)
    else $error("hot latch released");
  a_clear_on: assert property (p_clear_on)
    else $error("clear did not release latch");
  a_red_lat: assert property (p_red_lat)
    else $error("reduced level trip not latched");
  a_red_delay: assert property (p_red_delay)
    else $error("reduced level too early");
endmodule // scp_switch_ctrl_monitor
bind scp_switch_ctrl scp_switch_ctrl_monitor #(
  .TRIP_DELAY_CYC(TRIP_DELAY_CYC)) i_mon (.sys_clk_i, .rst_n_i,
  .over_temp_i, .reduced_trip_i, .reg_wr_i, .reg_rd_i, .reg_sel_i,
  .reg_wdata_i, .reg_rdata_o, .ch_on_o, .reduced_sel_o, .latched_o,
  .led_mode_o);
`default_nettype wire

// [verification/testbench.sv]
// Self-checking testbench for the switch channel control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {string nm; logic [2:0] src; logic [3:0] v;} scp_note_type;
  logic         sys_clk_i = 1'b0;  // 40 MHz clock
  logic         rst_n_i   = 1'b0;  // Reset, active low
  logic [3:0]   in_pin, oc, red, low, hvds, hot, v, rdata, chon, rsel, lat;
  logic [15:0]  lim;               // Retry limits
  logic         wr, rd;            // Strobes from the host model
  logic [1:0]   sel, led;
  logic [3:0]   wdat, seen;
  logic         csense;            // Current sense select output
  scp_note_type q[$], n;           // Expected results
  int           fail_count = 0, checks_done = 0, cyc = 0;
  int           seed = 32'h0543d8c7;
  always #12.5 sys_clk_i = ~sys_clk_i;
  scp_switch_ctrl #(.TRIP_DELAY_CYC(50)) i_scp_switch_ctrl (.sys_clk_i,
    .rst_n_i, .in_pin_i(in_pin), .oc_trip_i(oc), .reduced_trip_i(red),
    .low_trip_i(low), .high_vds_i(hvds), .over_temp_i(hot),
    .retry_limit_i(lim), .reg_wr_i(wr), .reg_rd_i(rd), .reg_sel_i(sel),
    .reg_wdata_i(wdat), .reg_rdata_o(rdata), .ch_on_o(chon),
    .reduced_sel_o(rsel), .latched_o(lat), .led_mode_o(led),
    .current_sense_o(csense));
  scp_host_model i_scp_host_model (.sys_clk_i, .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_sel_o(sel), .reg_wdata_o(wdat));
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  // Note an expected result; the watcher compares at the next edge
  task automatic note(string nm, logic [2:0] src, logic [3:0] e);
    q.push_back('{nm, src, e});
    step(1);
  endtask
  task automatic rdx(input logic [1:0] s, input logic [3:0] e);
    i_scp_host_model.rd(s);
    note("read data", 3'h0, e);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watcher: oldest note against the settled outputs
  always @(posedge sys_clk_i) begin
    if (q.size() > 0) begin
      n = q.pop_front();
      seen = n.src == 0 ? rdata : n.src == 1 ? chon : n.src == 2 ? lat :
             n.src == 3 ? rsel : n.src == 4 ? {2'b00, led} :
             {3'b000, csense};
      checks_done++;
      if (seen !== n.v) begin
        $display("[ERR] %s expected %h seen %h", n.nm, n.v, seen);
        fail_count++;
      end
    end
  end
  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {in_pin, oc, red, low, hvds, hot} = 24'h0;
    lim = (16'($random(seed)) & 16'hFFF0) | 16'h0001;  // Channel 0 limit 1
    repeat (16) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    step(4);
    for (int s = 0; s < 3; s++) rdx(2'(s), 4'h0);
    repeat (3) begin
      v = 4'($random(seed));
      i_scp_host_model.wr(2'h0, v);
      rdx(2'h0, v);
      i_scp_host_model.wr(2'h1, v & 4'hC);
      rdx(2'h1, v & 4'hC);
      note("led mode", 3'h4, {2'b00, v[3:2]});
      i_scp_host_model.wr(2'h2, v & 4'hE);
      rdx(2'h2, v & 4'hE);
      note("current sense", 3'h5, {3'h0, v[1]}); // Sense select output
    end
    i_scp_host_model.wr(2'h2, 4'h0);
    i_scp_host_model.wr(2'h0, 4'h1);
    step(3);
    note("channel on", 3'h1, 4'h1);
    i_scp_host_model.wr(2'h2, 4'h8);
    step(3);
    note("channel on", 3'h1, 4'h0);
    in_pin = 4'h1;
    step(5);
    note("channel on", 3'h1, 4'h1);
    i_scp_host_model.wr(2'h2, 4'h4);
    step(3);
    note("channel on", 3'h1, 4'h5);
    in_pin = 4'h0;
    i_scp_host_model.wr(2'h2, 4'h0);
    oc = 4'h1;
    step(6);
    note("channel on", 3'h1, 4'h0);
    rdx(2'h3, 4'h1);
    rdx(2'h3, 4'h1);
    oc = 4'h0;
    step(4);
    rdx(2'h3, 4'h1);
    rdx(2'h3, 4'h1);
    step(4000);
    note("channel on", 3'h1, 4'h1);
    rdx(2'h3, 4'h1);
    rdx(2'h3, 4'h0);
    oc = 4'h1;
    step(6);
    note("latched", 3'h2, 4'h1);
    rdx(2'h3, 4'h1);
    oc = 4'h0;
    step(3);
    i_scp_host_model.clear();
    step(2);
    note("channel on", 3'h1, 4'h1);
    note("reduced", 3'h3, 4'h0);
    step(60);
    note("reduced", 3'h3, 4'h1);
    red = 4'h1;
    step(6);
    note("latched", 3'h2, 4'h1);
    red = 4'h0;
    i_scp_host_model.clear();
    step(2);
    note("latched", 3'h2, 4'h0);
    hot = 4'h1;
    step(6);
    note("latched", 3'h2, 4'h1);
    i_scp_host_model.clear();
    step(2);
    note("latched", 3'h2, 4'h1);
    hot = 4'h0;
    step(4);
    i_scp_host_model.clear();
    step(2);
    note("channel on", 3'h1, 4'h1);
    i_scp_host_model.wr(2'h0, 4'h0);
    step(3);
    i_scp_host_model.wr(2'h0, 4'h1);
    {hvds, low} = 8'h11;
    step(6);
    note("latched", 3'h2, 4'h1);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
